// [hw/urx_top.sv]
// Serial receiver/transmitter with error flags, break, address detect,
// loopback, baud divisor, auto-baud capture route and power states.
// Assumes an APB3 master on core_clk; sleep and idle come from logic on core_clk.
//
// The APB interface to the registers was left to the implementer.
module urx_top #(
	parameter int RX_DEPTH = 4,
	parameter int TX_DEPTH = 4
) (
	input  wire logic                       core_clk,
	input  wire logic                       rst,
	input  wire logic [urx_pkg::ADDR_W-1:0] paddr,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic                       serial_receive_pin,
	output logic                            serial_transmit_pin,
	input  wire logic                       sleep_mode,
	input  wire logic                       cpu_idle,
	output logic                            capture_route,
	output logic                            rx_interrupt,
	output logic                            tx_interrupt
);
	import urx_pkg::*;

	localparam int RPW = $clog2(RX_DEPTH);
	localparam int TPW = $clog2(TX_DEPTH);

	// Address match, used by both read mux and write strobes
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] t);
		hit = (a == t);
	endfunction

	// Registers
	logic [15:0]         uart_mode_control;
	logic [15:0]         uart_baud_divisor;
	logic                tx_isel, tx_brk, tx_en, addr_en, overrun_error;
	logic [1:0]          receive_interrupt_select;
	logic [15:0]         baud_cnt;
	logic                rx_meta, rx_sync, rx_prev, pin_prev;
	logic [10:0]         rx_mem [RX_DEPTH];
	logic [RPW-1:0]      rx_wp, rx_rp;
	logic [RPW:0]        rx_cnt;
	logic [8:0]          tx_mem [TX_DEPTH];
	logic [TPW-1:0]      tx_wp, tx_rp;
	logic [TPW:0]        tx_cnt;
	urx_rx_state_e       rx_state;
	logic [3:0]          rx_samp, rx_bit;
	logic [8:0]          receive_shift_register;
	logic                rx_par, rx_parity_error, rx_framing_error;
	urx_tx_state_e       tx_state;
	logic [3:0]          tx_samp, tx_bit;
	logic [8:0]          tx_shift;
	logic                tx_line;

	// Bus decode
	wire logic           setup_ph  = psel & ~penable;
	wire logic           access_ph = psel & penable;
	wire logic           wr        = access_ph & pwrite;
	wire logic           rd        = access_ph & ~pwrite;
	wire logic           sel_mode  = hit(paddr, ADDR_MODE);
	wire logic           sel_sta   = hit(paddr, ADDR_STA);
	wire logic           sel_txd   = hit(paddr, ADDR_TXD);
	wire logic           sel_rxd   = hit(paddr, ADDR_RXD);
	wire logic           sel_brg   = hit(paddr, ADDR_BRG);
	wire logic           mapped    = sel_mode | sel_sta | sel_txd | sel_rxd | sel_brg;
	assign pready  = access_ph;
	assign pslverr = access_ph & ~mapped;

	// Mode fields and run qualification
	wire logic [1:0]     data_parity_select = uart_mode_control[M_PD_HI:M_PD_LO];
	wire logic           stop_bits_select   = uart_mode_control[M_STOP_BITS_SELECT];
	wire logic           module_enable      = uart_mode_control[M_ENABLE];
	wire logic           stop_in_idle       = uart_mode_control[M_SIDL];
	wire logic           loopback_enable    = uart_mode_control[M_LPBK];
	wire logic           nine_bit  = (data_parity_select == PD_9N);
	wire logic           has_par   = (data_parity_select == PD_8E) | (data_parity_select == PD_8O);
	wire logic           odd_par   = (data_parity_select == PD_8O);
	wire logic [3:0]     last_bit  = nine_bit ? BIT_LAST9 : BIT_LAST8;
	wire logic           abort     = ~module_enable | sleep_mode;
	wire logic           run       = ~abort & ~(cpu_idle & stop_in_idle);
	wire logic           tick      = run & (baud_cnt == 16'h0000);

	// Receive line source and start edge
	wire logic           rx_line   = loopback_enable ? tx_line : rx_sync;
	wire logic           rx_fall   = rx_prev & ~rx_line;
	wire logic           pin_fall  = pin_prev & ~rx_sync;
	wire logic           samp_bit  = tick & (rx_samp == SAMP_LAST);

	// FIFO status and head
	wire logic           rx_full   = (rx_cnt == RX_DEPTH[RPW:0]);
	wire logic           rx_avail  = (rx_cnt != '0);
	wire logic [10:0]    rx_head   = rx_avail ? rx_mem[rx_rp] : 11'h000;
	wire logic           tx_full   = (tx_cnt == TX_DEPTH[TPW:0]);
	wire logic           tx_empty  = (tx_cnt == '0);
	wire logic           receiver_idle = (rx_state == RX_IDLE) | (rx_state == RX_WAITH);
	wire logic           trmt      = tx_empty & (tx_state == TX_IDLE);

	// Receive push, overrun, transmit push, pops and load
	wire logic           rx_done   = run & (rx_state == RX_DONE);
	wire logic           rx_push   = rx_done & ~rx_full;
	wire logic           ovr_set   = rx_done & rx_full;
	wire logic           rx_pop    = rd & sel_rxd & rx_avail;
	wire logic           tx_push   = wr & sel_txd & ~tx_full & module_enable;
	wire logic           tx_load   = run & tx_en & ~tx_empty & (tx_state == TX_IDLE);
	wire logic           ovr_clr   = wr & sel_sta & ~pwdata[S_OVERRUN_ERROR];

	// Receive and transmit interrupt conditions
	wire logic           addr_mode = addr_en & nine_bit;
	wire logic           cnt_ok    = (receive_interrupt_select == RXIS_3) ? (rx_cnt == 3'd2) :
	                                 (receive_interrupt_select == RXIS_4) ? (rx_cnt == 3'd3) : 1'b1;
	wire logic           rx_evt    = rx_push & (addr_mode ? receive_shift_register[8] : cnt_ok);
	wire logic           wake_evt  = sleep_mode & module_enable & uart_mode_control[M_WAKE] & pin_fall;
	wire logic           tx_evt    = tx_load & (~tx_isel | (tx_cnt == 3'd1));

	// Read mux
	wire logic [15:0]    sta_rd = {tx_isel, 3'b000, tx_brk, tx_en, tx_full, trmt,
	                               receive_interrupt_select, addr_en, receiver_idle,
	                               rx_head[9], rx_head[10], overrun_error, rx_avail};
	wire logic [15:0]    rd_mux = sel_mode ? uart_mode_control :
	                              sel_sta  ? sta_rd :
	                              sel_rxd  ? {7'h00, rx_head[8:0]} :
	                              sel_brg  ? uart_baud_divisor : 16'h0000;

	// Read data captured in setup, stable through the access
	always_ff @(posedge core_clk) begin
		if (rst)
			prdata <= 32'h0000_0000;
		else if (setup_ph)
			prdata <= {16'h0000, rd_mux};
	end

	// Software registers; sleep never touches them
	always_ff @(posedge core_clk) begin
		if (rst) begin
			uart_mode_control        <= MODE_RST;
			uart_baud_divisor        <= BRG_RST;
			tx_isel                  <= STA_RST[S_TXISEL];
			tx_brk                   <= STA_RST[S_TXBRK];
			tx_en                    <= STA_RST[S_TXEN];
			receive_interrupt_select <= STA_RST[S_RXIS_HI:S_RXIS_LO];
			addr_en                  <= STA_RST[S_ADDRESS_DETECT_ENABLE];
		end else begin
			if (wr & sel_mode)
				uart_mode_control <= pwdata[15:0] & MODE_WMASK;
			if (wr & sel_brg)
				uart_baud_divisor <= pwdata[15:0];
			if (wr & sel_sta) begin
				tx_isel                  <= pwdata[S_TXISEL];
				receive_interrupt_select <= pwdata[S_RXIS_HI:S_RXIS_LO];
				addr_en                  <= pwdata[S_ADDRESS_DETECT_ENABLE];
			end
			if (~module_enable) begin
				tx_brk <= 1'b0;
				tx_en  <= 1'b0;
			end else if (wr & sel_sta) begin
				tx_brk <= pwdata[S_TXBRK];
				tx_en  <= pwdata[S_TXEN];
			end
		end
	end

	// Overrun flag: set wins over software clear
	always_ff @(posedge core_clk) begin
		if (rst)
			overrun_error <= STA_RST[S_OVERRUN_ERROR];
		else if (~module_enable)
			overrun_error <= 1'b0;
		else if (ovr_set)
			overrun_error <= 1'b1;
		else if (ovr_clr)
			overrun_error <= 1'b0;
	end

	// Baud divisor counter, one tick per N+1 clocks
	always_ff @(posedge core_clk) begin
		if (rst)
			baud_cnt <= 16'h0000;
		else if (~module_enable)
			baud_cnt <= 16'h0000;
		else if (tick)
			baud_cnt <= uart_baud_divisor;
		else if (run)
			baud_cnt <= baud_cnt - 16'h0001;
	end

	// Pin synchroniser and edge history
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rx_meta  <= 1'b1;
			rx_sync  <= 1'b1;
			rx_prev  <= 1'b1;
			pin_prev <= 1'b1;
		end else begin
			rx_meta  <= serial_receive_pin;
			rx_sync  <= rx_meta;
			rx_prev  <= rx_line;
			pin_prev <= rx_sync;
		end
	end

	// Receive FIFO with per-word error flags
	always_ff @(posedge core_clk) begin
		if (rst | ~module_enable) begin
			rx_wp  <= '0;
			rx_rp  <= '0;
			rx_cnt <= '0;
		end else begin
			if (rx_push) begin
				rx_mem[rx_wp] <= {rx_framing_error, rx_parity_error, receive_shift_register};
				rx_wp         <= rx_wp + 1'b1;
			end
			if (rx_pop)
				rx_rp <= rx_rp + 1'b1;
			rx_cnt <= rx_cnt + {{RPW{1'b0}}, rx_push} - {{RPW{1'b0}}, rx_pop};
		end
	end

	// Receive state machine
	always_ff @(posedge core_clk) begin
		if (rst | abort) begin
			rx_state <= RX_IDLE;
			rx_samp  <= 4'h0;
			rx_bit   <= 4'h0;
			rx_par   <= 1'b0;
			rx_parity_error  <= 1'b0;
			rx_framing_error  <= 1'b0;
			if (rst)
				receive_shift_register <= 9'h000;
		end else if (run) begin
			if (tick)
				rx_samp <= rx_samp + 4'h1;
			case (rx_state)
				RX_IDLE: begin
					if (rx_fall & ~overrun_error) begin
						rx_state <= RX_START;
						rx_samp  <= 4'h0;
					end
				end
				RX_START: begin
					if (tick & (rx_samp == SAMP_MID)) begin
						rx_state <= rx_line ? RX_IDLE : RX_DATA;
						rx_samp  <= 4'h0;
						rx_bit   <= 4'h0;
						rx_par   <= 1'b0;
						rx_parity_error  <= 1'b0;
						rx_framing_error  <= 1'b0;
						receive_shift_register <= 9'h000;
					end
				end
				RX_DATA: begin
					if (samp_bit) begin
						receive_shift_register[rx_bit] <= rx_line;
						rx_par <= rx_par ^ rx_line;
						rx_bit <= rx_bit + 4'h1;
						if (rx_bit == last_bit)
							rx_state <= has_par ? RX_PAR : RX_STOP1;
					end
				end
				RX_PAR: begin
					if (samp_bit) begin
						rx_parity_error  <= rx_par ^ rx_line ^ odd_par;
						rx_state <= RX_STOP1;
					end
				end
				RX_STOP1: begin
					if (samp_bit) begin
						rx_framing_error  <= ~rx_line;
						rx_state <= stop_bits_select ? RX_STOP2 : RX_DONE;
					end
				end
				RX_STOP2: begin
					if (samp_bit) begin
						rx_framing_error  <= rx_framing_error | ~rx_line;
						rx_state <= RX_DONE;
					end
				end
				RX_DONE: begin
					// Break ends here with zeros and framing set
					rx_state <= rx_framing_error ? RX_WAITH : RX_IDLE;
				end
				RX_WAITH: begin
					if (rx_line)
						rx_state <= RX_IDLE;
				end
				default: rx_state <= RX_IDLE;
			endcase
		end
	end

	// Transmit FIFO
	always_ff @(posedge core_clk) begin
		if (rst | ~module_enable) begin
			tx_wp  <= '0;
			tx_rp  <= '0;
			tx_cnt <= '0;
		end else begin
			if (tx_push) begin
				tx_mem[tx_wp] <= pwdata[8:0];
				tx_wp         <= tx_wp + 1'b1;
			end
			if (tx_load)
				tx_rp <= tx_rp + 1'b1;
			tx_cnt <= tx_cnt + {{TPW{1'b0}}, tx_push} - {{TPW{1'b0}}, tx_load};
		end
	end

	// Transmit state machine
	wire logic tx_step = tick & (tx_samp == SAMP_LAST);
	always_ff @(posedge core_clk) begin
		if (rst | abort) begin
			tx_state <= TX_IDLE;
			tx_samp  <= 4'h0;
			tx_bit   <= 4'h0;
			tx_shift <= 9'h000;
		end else if (run) begin
			if (tick)
				tx_samp <= tx_samp + 4'h1;
			case (tx_state)
				TX_IDLE: begin
					if (tx_load) begin
						tx_shift <= tx_mem[tx_rp];
						tx_state <= TX_START;
						tx_samp  <= 4'h0;
					end
				end
				TX_START: begin
					if (tx_step) begin
						tx_state <= TX_DATA;
						tx_bit   <= 4'h0;
					end
				end
				TX_DATA: begin
					if (tx_step) begin
						tx_bit <= tx_bit + 4'h1;
						if (tx_bit == last_bit) begin
							tx_state <= has_par ? TX_PAR : TX_STOP;
							tx_bit   <= 4'h0;
						end
					end
				end
				TX_PAR: begin
					if (tx_step)
						tx_state <= TX_STOP;
				end
				TX_STOP: begin
					if (tx_step) begin
						tx_bit <= tx_bit + 4'h1;
						if (tx_bit[0] | ~stop_bits_select)
							tx_state <= TX_IDLE;
					end
				end
				default: tx_state <= TX_IDLE;
			endcase
		end
	end

	// Transmit line level; break forces low except in sleep or while disabled, when the pin is held high
	wire logic tx_par_bit = (^tx_shift[7:0]) ^ odd_par;
	wire logic tx_frame   = (tx_state == TX_START) ? 1'b0 :
	                        (tx_state == TX_DATA)  ? tx_shift[tx_bit] :
	                        (tx_state == TX_PAR)   ? tx_par_bit : 1'b1;

	// Registered pin, events and capture route
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tx_line             <= 1'b1;
			serial_transmit_pin <= 1'b1;
			capture_route       <= 1'b1;
			rx_interrupt        <= 1'b0;
			tx_interrupt        <= 1'b0;
		end else begin
			tx_line             <= abort ? 1'b1 : (tx_frame & ~tx_brk);
			serial_transmit_pin <= abort ? 1'b1 : (tx_frame & ~tx_brk);
			capture_route       <= uart_mode_control[M_ABAUD] ? rx_line : 1'b1;
			rx_interrupt        <= rx_evt | wake_evt;
			tx_interrupt        <= tx_evt;
		end
	end

endmodule

// [include/urx_pkg.sv]
// Package for the serial receiver/transmitter block: register map,
// field positions, reset values, frame encodings and state types.
// Assumes an APB master with 32-bit data; registers use the low 16 bits.
package urx_pkg;

	// Printed register indices; byte address is four times the index
	localparam logic [11:0] IDX_MODE = 12'h20C;
	localparam logic [11:0] IDX_STA  = 12'h20E;
	localparam logic [11:0] IDX_TXD  = 12'h210;
	localparam logic [11:0] IDX_RXD  = 12'h212;
	localparam logic [11:0] IDX_BRG  = 12'h214;
	localparam int          ADDR_W   = 12;
	localparam logic [11:0] ADDR_MODE = {IDX_MODE[9:0], 2'b00};
	localparam logic [11:0] ADDR_STA  = {IDX_STA[9:0], 2'b00};
	localparam logic [11:0] ADDR_TXD  = {IDX_TXD[9:0], 2'b00};
	localparam logic [11:0] ADDR_RXD  = {IDX_RXD[9:0], 2'b00};
	localparam logic [11:0] ADDR_BRG  = {IDX_BRG[9:0], 2'b00};

	// Reset values
	localparam logic [15:0] MODE_RST = 16'h0000;
	localparam logic [15:0] STA_RST  = 16'h0110;
	localparam logic [15:0] BRG_RST  = 16'h0000;
	localparam logic [15:0] MODE_WMASK = 16'hA0E7;

	// Mode control fields
	localparam int M_ENABLE = 15;
	localparam int M_SIDL   = 13;
	localparam int M_WAKE   = 7;
	localparam int M_LPBK   = 6;
	localparam int M_ABAUD  = 5;
	localparam int M_PD_HI  = 2;
	localparam int M_PD_LO  = 1;
	localparam int M_STOP_BITS_SELECT  = 0;

	// Status control fields
	localparam int S_TXISEL = 15;
	localparam int S_TXBRK  = 11;
	localparam int S_TXEN   = 10;
	localparam int S_TXBF   = 9;
	localparam int S_TRMT   = 8;
	localparam int S_RXIS_HI = 7;
	localparam int S_RXIS_LO = 6;
	localparam int S_ADDRESS_DETECT_ENABLE  = 5;
	localparam int S_RECEIVER_IDLE  = 4;
	localparam int S_PARITY_ERROR   = 3;
	localparam int S_FRAMING_ERROR   = 2;
	localparam int S_OVERRUN_ERROR   = 1;
	localparam int S_RXDA   = 0;

	// Data length and parity encodings
	localparam logic [1:0] PD_8N = 2'b00;
	localparam logic [1:0] PD_8E = 2'b01;
	localparam logic [1:0] PD_8O = 2'b10;
	localparam logic [1:0] PD_9N = 2'b11;

	// Receive interrupt select encodings
	localparam logic [1:0] RXIS_3 = 2'b10;
	localparam logic [1:0] RXIS_4 = 2'b11;

	// Oversampling: sixteen ticks per bit, start checked mid-bit
	localparam logic [3:0] SAMP_MID  = 4'h7;
	localparam logic [3:0] SAMP_LAST = 4'hF;
	localparam logic [3:0] BIT_LAST8 = 4'h7;
	localparam logic [3:0] BIT_LAST9 = 4'h8;

	typedef enum logic [2:0] {
		RX_IDLE  = 3'b000,
		RX_START = 3'b001,
		RX_DATA  = 3'b010,
		RX_PAR   = 3'b011,
		RX_STOP1 = 3'b100,
		RX_STOP2 = 3'b101,
		RX_DONE  = 3'b110,
		RX_WAITH = 3'b111
	} urx_rx_state_e;

	typedef enum logic [2:0] {
		TX_IDLE  = 3'b000,
		TX_START = 3'b001,
		TX_DATA  = 3'b010,
		TX_PAR   = 3'b011,
		TX_STOP  = 3'b100
	} urx_tx_state_e;

endpackage

// [test/urx_top_properties.sv]
// Checker on the serial block ports: APB answer, register readback,
// transmit pin levels in sleep, off and halt, wake pulse, capture route.
// Assumes it is bound into urx_top; shadows follow mode and divisor writes.
module urx_top_properties
	import urx_pkg::*;
#(
	parameter int RX_DEPTH = 4,
	parameter int TX_DEPTH = 4
) (
	input wire logic              core_clk,
	input wire logic              rst,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              serial_receive_pin,
	input wire logic              serial_transmit_pin,
	input wire logic              sleep_mode,
	input wire logic              cpu_idle,
	input wire logic              capture_route,
	input wire logic              rx_interrupt,
	input wire logic              tx_interrupt
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mode_sh;
	logic [15:0] brg_sh;
	// Access-phase write strobe and address decode
	wire         wr_acc = psel && penable && pwrite;
	wire         mapped = (paddr == ADDR_MODE) || (paddr == ADDR_STA) || (paddr == ADDR_TXD) ||
		(paddr == ADDR_RXD) || (paddr == ADDR_BRG);

	// Shadow copies of writable mode bits and divisor
	always_ff @(posedge core_clk) begin
		if (rst) begin
			mode_sh <= MODE_RST;
			brg_sh <= BRG_RST;
		end else begin
			if (wr_acc && paddr == ADDR_MODE)
				mode_sh <= pwdata[15:0] & MODE_WMASK;
			if (wr_acc && paddr == ADDR_BRG)
				brg_sh <= pwdata[15:0];
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	// Read setup phase alone, and a wake edge while asleep
	sequence s_rd_setup; psel && !penable && !pwrite; endsequence
	sequence s_wake_edge; sleep_mode && mode_sh[M_ENABLE] && mode_sh[M_WAKE] && $fell(serial_receive_pin); endsequence
	// Auto-baud route on with the external pin feeding the receiver
	sequence s_cap_on; mode_sh[M_ABAUD] && !mode_sh[M_LPBK]; endsequence

	property p_ready; psel && penable |-> pready; endproperty
	property p_err; psel && penable |-> pslverr == !mapped; endproperty
	property p_upper; psel && penable && !pwrite |-> prdata[31:16] == 16'h0000; endproperty
	property p_mode; s_rd_setup ##1 (penable && paddr == ADDR_MODE) |-> prdata[15:0] == mode_sh; endproperty
	property p_brg; s_rd_setup ##1 (penable && paddr == ADDR_BRG) |-> prdata[15:0] == brg_sh; endproperty
	property p_sleep_tx; sleep_mode [*3] |-> serial_transmit_pin; endproperty
	property p_off_tx; (!mode_sh[M_ENABLE]) [*3] |-> serial_transmit_pin; endproperty
	property p_cap; (!mode_sh[M_ABAUD]) [*3] |-> capture_route; endproperty
	property p_wake; s_wake_edge ##1 sleep_mode [*2] |-> ##[0:4] rx_interrupt; endproperty
	property p_halt; (cpu_idle && mode_sh[M_SIDL]) [*3] |-> $stable(serial_transmit_pin) && !rx_interrupt; endproperty
	property p_irq; rx_interrupt |=> !rx_interrupt; endproperty
	property p_cap_on; s_cap_on [*4] |-> capture_route == $past(serial_receive_pin, 3); endproperty

	a_ready: assert property (p_ready)
		else $error("pready low in access phase");
	a_err: assert property (p_err)
		else $error("pslverr does not match address decode");
	a_upper: assert property (p_upper)
		else $error("upper read data not zero");
	a_mode: assert property (p_mode)
		else $error("mode readback differs from last write");
	a_brg: assert property (p_brg)
		else $error("divisor readback differs from last write");
	a_sleep_tx: assert property (p_sleep_tx)
		else $error("transmit pin low during sleep");
	a_off_tx: assert property (p_off_tx)
		else $error("transmit pin low while disabled");
	a_cap: assert property (p_cap)
		else $error("capture route not high with auto-baud off");
	a_wake: assert property (p_wake)
		else $error("no receive interrupt after wake edge");
	a_halt: assert property (p_halt)
		else $error("activity while halted in idle");
	a_irq: assert property (p_irq)
		else $error("receive interrupt longer than one cycle");
	a_cap_on: assert property (p_cap_on)
		else $error("capture route does not follow receive line");
endmodule

bind urx_top urx_top_properties #(.RX_DEPTH(RX_DEPTH), .TX_DEPTH(TX_DEPTH)) props_u (
	.core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.serial_receive_pin(serial_receive_pin), .serial_transmit_pin(serial_transmit_pin),
	.sleep_mode(sleep_mode), .cpu_idle(cpu_idle), .capture_route(capture_route),
	.rx_interrupt(rx_interrupt), .tx_interrupt(tx_interrupt));

// [test/urx_remote.sv]
// Remote serial device: drives framed bits onto the receive line and
// decodes eight-bit frames from the transmit line.
// Assumes the line idles high and one bit lasts bit_clks core clocks.
module urx_remote (
	input  wire logic core_clk,
	output logic      line,
	input  wire logic tx_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	int         bit_clks = 16;
	int         got_n = 0;
	logic [7:0] got;

	initial line = 1'b1;

	// Send n bits, start bit first, then back to mark level
	task automatic send(input logic [15:0] fr, input int n);
		@(posedge core_clk);
		for (int i = 0; i < n; i++) begin
			line <= fr[i];
			repeat (bit_clks) @(posedge core_clk);
		end
		line <= 1'b1;
	endtask

	// Decode a frame from the transmit pin, sampled mid-bit
	initial forever begin
		@(posedge core_clk iff tx_pin === 1'b0);
		repeat (bit_clks / 2) @(posedge core_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (bit_clks) @(posedge core_clk);
			got[i] = tx_pin;
		end
		repeat (bit_clks) @(posedge core_clk);
		got_n++;
	end
endmodule

// [test/test_uart_rx_error_baud_power.sv]
// Testbench for the serial block: APB tasks, a remote device on the pins,
// and a read monitor that checks each answer against a queued note.
// Assumes a 125 MHz core_clk and zero-wait APB answers.
module test_uart_rx_error_baud_power;
	timeunit 1ns;
	timeprecision 1ps;
	import urx_pkg::*;
	logic              core_clk, rst, psel, penable, pwrite, sleep_mode, cpu_idle, p;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata;
	logic              pready, pslverr, rx_pin, tx_pin, cap, rx_irq, tx_irq;
	logic [32:0]       exp_q[$];
	logic [32:0]       e;
	logic [15:0]       r;
	logic [7:0]        d;
	logic [7:0]        held[6];
	logic [1:0]        pd;
	int                errors, cmp_count, irq_n, tx_n, base, seed;

	always #4 core_clk = ~core_clk;
	always @(posedge core_clk) if (rx_irq === 1'b1) irq_n++;
	always @(posedge core_clk) if (tx_irq === 1'b1) tx_n++;

	urx_top dut_u (.core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_receive_pin(rx_pin),
		.serial_transmit_pin(tx_pin), .sleep_mode(sleep_mode), .cpu_idle(cpu_idle), .capture_route(cap),
		.rx_interrupt(rx_irq), .tx_interrupt(tx_irq));
	urx_remote remote_u (.core_clk(core_clk), .line(rx_pin), .tx_pin(tx_pin));

	task chk(input string nm, input logic [16:0] ex, input logic [16:0] got);
		cmp_count++;
		if (got !== ex) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task wrap_up;
		$display("counts: %0d compares, %0d mismatches", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// One APB transfer, access held until pready
	task apb(input logic [11:0] a, input logic w, input logic [15:0] v);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= {16'h0000, v};
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			errors++;
			wrap_up;
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [11:0] a, input logic [15:0] v);
		apb(a, 1'b1, v);
	endtask

	// Note expected error flag and masked data, then read
	task rd(input logic [11:0] a, input logic [15:0] ex, input logic [15:0] m);
		logic hit;
		hit = (a == ADDR_MODE) || (a == ADDR_STA) || (a == ADDR_TXD) || (a == ADDR_RXD) || (a == ADDR_BRG);
		exp_q.push_back({!hit, m, ex & m});
		apb(a, 1'b0, 16'h0000);
	endtask

	// Receive one frame, then check status, data word and empty buffer
	task rx1(input logic [15:0] mode, input logic [15:0] fr, input int n, input logic [15:0] sm,
		input logic [15:0] se, input logic [8:0] dat);
		wr(ADDR_MODE, mode);
		remote_u.send(fr, n);
		repeat (24) @(posedge core_clk);
		rd(ADDR_STA, se, sm);
		rd(ADDR_RXD, {7'h00, dat}, 16'h01FF);
		rd(ADDR_STA, 16'h0000, 16'h0001);
	endtask

	task done_t(input string s);
		$display("test %s done", s);
	endtask

	// Read monitor: oldest note against each read answer
	always @(posedge core_clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			e = exp_q.pop_front();
			chk("prdata", {e[32], e[15:0]}, {pslverr, prdata[15:0] & e[31:16]});
		end
	end

	initial begin
		repeat (100000) @(posedge core_clk);
		errors++;
		wrap_up;
	end

	initial begin
		seed = 32'h39b1;
		errors = 0;
		cmp_count = 0;
		irq_n = 0;
		tx_n = 0;
		core_clk = 1'b0;
		rst = 1'b1;
		{psel, penable, pwrite, sleep_mode, cpu_idle} = 5'b00000;
		paddr = '0;
		pwdata = '0;
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		rd(ADDR_MODE, MODE_RST, 16'hFFFF);
		rd(ADDR_STA, STA_RST, 16'hFFFF);
		rd(ADDR_BRG, BRG_RST, 16'hFFFF);
		rd(12'h004, 16'h0000, 16'hFFFF);
		done_t("reset");
		wr(ADDR_BRG, 16'hFFFF);
		rd(ADDR_BRG, 16'hFFFF, 16'hFFFF);
		r = 16'($random(seed));
		wr(ADDR_BRG, r);
		rd(ADDR_BRG, r, 16'hFFFF);
		wr(ADDR_BRG, 16'h0000);
		wr(ADDR_MODE, 16'hFFFF);
		rd(ADDR_MODE, MODE_WMASK, 16'hFFFF);
		wr(ADDR_STA, 16'h0400);
		done_t("registers");
		d = 8'($random(seed));
		fork
			rx1(16'h8000, 16'({1'b1, d, 1'b0}), 10, 16'h001F, 16'h0011, {1'b0, d});
			begin
				repeat (90) @(posedge core_clk);
				rd(ADDR_STA, 16'h0000, 16'h0010);
			end
		join
		for (int k = 0; k < 3; k++) begin
			d = 8'($random(seed));
			pd = (k == 0) ? PD_8E : (k == 1) ? PD_8O : PD_8N;
			p = (k < 2) ? ^d : 1'b1;
			rx1(16'h8000 | {13'h0000, pd, 1'b0}, 16'({1'b1, p, d, 1'b0}), 11, 16'h000C,
				(k == 1) ? 16'h0008 : 16'h0000, {1'b0, d});
		end
		done_t("parity");
		rx1(16'h8000, 16'({1'b0, d, 1'b0}), 10, 16'h0004, 16'h0004, {1'b0, d});
		rx1(16'h8001, 16'({2'b01, d, 1'b0}), 11, 16'h0004, 16'h0004, {1'b0, d});
		rx1(16'h8001, 16'({2'b11, d, 1'b0}), 11, 16'h0004, 16'h0000, {1'b0, d});
		rx1(16'h8000, 16'h0000, 16, 16'h0015, 16'h0015, 9'h000);
		wr(ADDR_BRG, 16'h0001);
		remote_u.bit_clks = 32;
		rx1(16'h8020, 16'({1'b1, d, 1'b0}), 10, 16'h000F, 16'h0001, {1'b0, d});
		remote_u.bit_clks = 16;
		wr(ADDR_BRG, 16'h0000);
		done_t("framing, break and divisor");
		wr(ADDR_STA, 16'h0480);
		base = irq_n;
		for (int k = 0; k < 6; k++) begin
			held[k] = 8'($random(seed));
			remote_u.send(16'({1'b1, held[k], 1'b0}), 10);
			repeat (24) @(posedge core_clk);
			if (k == 3) begin
				rd(ADDR_STA, 16'h0001, 16'h0003);
				chk("rx_interrupt", 17'd1, 17'(irq_n - base));
			end
			if (k == 4) begin
				rd(ADDR_STA, 16'h0003, 16'h0003);
				for (int j = 0; j < 4; j++)
					rd(ADDR_RXD, {8'h00, held[j]}, 16'h01FF);
			end
		end
		rd(ADDR_STA, 16'h0002, 16'h0003);
		wr(ADDR_STA, 16'h0400);
		rd(ADDR_STA, 16'h0000, 16'h0003);
		done_t("overrun");
		wr(ADDR_STA, 16'h0420);
		wr(ADDR_MODE, 16'h8006);
		base = irq_n;
		remote_u.send(16'({2'b10, d, 1'b0}), 11);
		remote_u.send(16'({2'b11, ~d, 1'b0}), 11);
		repeat (24) @(posedge core_clk);
		chk("rx_interrupt", 17'd1, 17'(irq_n - base));
		rd(ADDR_RXD, {8'h00, d}, 16'h01FF);
		rd(ADDR_RXD, {8'h01, ~d}, 16'h01FF);
		wr(ADDR_STA, 16'h0400);
		done_t("address detect");
		wr(ADDR_MODE, 16'h8040);
		base = remote_u.got_n;
		fork
			wr(ADDR_TXD, {8'h00, d});
			remote_u.send(16'h0200, 10);
		join
		for (int n = 0; n < 400 && remote_u.got_n == base; n++) @(posedge core_clk);
		if (remote_u.got_n == base) begin
			errors++;
			wrap_up;
		end
		chk("serial", {9'h000, d}, {9'h000, remote_u.got});
		chk("tx_interrupt", 17'd1, 17'(tx_n));
		repeat (24) @(posedge core_clk);
		rd(ADDR_RXD, {8'h00, d}, 16'h01FF);
		rd(ADDR_STA, 16'h0000, 16'h0001);
		done_t("loopback");
		wr(ADDR_MODE, 16'h8080);
		wr(ADDR_TXD, {8'h00, d});
		repeat (40) @(posedge core_clk);
		sleep_mode <= 1'b1;
		base = irq_n;
		repeat (4) @(posedge core_clk);
		chk("tx_pin", 17'd1, {16'h0000, tx_pin});
		remote_u.send(16'h0000, 1);
		repeat (8) @(posedge core_clk);
		chk("rx_interrupt", 17'd1, 17'(irq_n - base));
		sleep_mode <= 1'b0;
		rd(ADDR_MODE, 16'h8080, 16'hFFFF);
		rd(ADDR_BRG, 16'h0000, 16'hFFFF);
		done_t("sleep");
		cpu_idle <= 1'b1;
		rx1(16'h8000, 16'({1'b1, d, 1'b0}), 10, 16'h000F, 16'h0001, {1'b0, d});
		wr(ADDR_MODE, 16'hA000);
		remote_u.send(16'({1'b1, d, 1'b0}), 10);
		cpu_idle <= 1'b0;
		repeat (24) @(posedge core_clk);
		rd(ADDR_STA, 16'h0000, 16'h0001);
		done_t("idle");
		wrap_up;
	end
endmodule
